// File: design/adcsq_defs.svh
// offsets, field positions and reset values of the sequencer run control
`ifndef ADCSQ_DEFS_SVH
`define ADCSQ_DEFS_SVH
`define ADCSQ_OFS_CTRL1 4'h0
`define ADCSQ_OFS_CTRL2 4'h1
`define ADCSQ_OFS_MAXCONV 4'h2
`define ADCSQ_OFS_STAT 4'h3
`define ADCSQ_OFS_IRQ_ST 4'h4
`define ADCSQ_OFS_IRQ_MSK 4'h5
`define ADCSQ_C1_CONT 6
`define ADCSQ_C1_OVRD 5
`define ADCSQ_C1_CASC 4
`define ADCSQ_C1_MASK 16'h0070
`define ADCSQ_C2_CASC_B 15
`define ADCSQ_C2_RST1 14
`define ADCSQ_C2_SOC1 13
`define ADCSQ_C2_PWMA1 8
`define ADCSQ_C2_PIN1 7
`define ADCSQ_C2_RST2 6
`define ADCSQ_C2_SOC2 5
`define ADCSQ_C2_PWMB2 0
`define ADCSQ_C2_MASK 16'hEDED
`define ADCSQ_RST16 16'h0000
`define ADCSQ_CONV_CYC 4'h4
`endif

// File: design/adcsq_pkg.sv
// types of the sequencer run control
package adcsq_pkg;
  typedef enum logic [1:0] {
    ADCSQ_IDLE = 2'b00,
    ADCSQ_CONV = 2'b01,
    ADCSQ_STEP = 2'b10
  } adcsq_state_t;
endpackage

// File: design/adcsq_run_ctrl.sv
// autoconversion sequencer run control with register port and interrupt
`timescale 1ns/1ps
`include "adcsq_defs.svh"
module adcsq_run_ctrl
  import adcsq_pkg::*;
#(
  parameter logic [3:0] CONV_CYCLES = `ADCSQ_CONV_CYC
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [3:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  input wire logic PWM_TRIG_A,
  input wire logic PWM_TRIG_B,
  input wire logic PIN_TRIG,
  output logic [3:0] UNIT_ONE_STATE,
  output logic [3:0] UNIT_TWO_STATE,
  output logic UNIT_ONE_BUSY,
  output logic UNIT_TWO_BUSY,
  output logic CONV_START,
  output logic [3:0] CONV_INDEX,
  output logic IRQ
);

  // control registers
  logic [15:0] ctrl1_ff;
  logic [15:0] ctrl2_ff;
  logic [7:0] maxconv_ff;
  logic [1:0] irq_st_ff;
  logic [1:0] irq_msk_ff;
  logic [15:0] rdata_ff;
  logic pin_s1_ff;
  logic pin_s2_ff;
  logic pin_d_ff;

  wire wr_c1 = WR && (ADDR == `ADCSQ_OFS_CTRL1);
  wire wr_c2 = WR && (ADDR == `ADCSQ_OFS_CTRL2);
  wire wr_mx = WR && (ADDR == `ADCSQ_OFS_MAXCONV);
  wire wr_is = WR && (ADDR == `ADCSQ_OFS_IRQ_ST);
  wire wr_im = WR && (ADDR == `ADCSQ_OFS_IRQ_MSK);

  wire cont = ctrl1_ff[`ADCSQ_C1_CONT];
  wire ovrd = ctrl1_ff[`ADCSQ_C1_OVRD];
  wire casc = ctrl1_ff[`ADCSQ_C1_CASC];

  // software reset pulses; reset beats start written beside it
  wire rst1 = wr_c2 && WDATA[`ADCSQ_C2_RST1];
  wire rst2 = wr_c2 && WDATA[`ADCSQ_C2_RST2] && !casc;
  wire sw1 = wr_c2 && WDATA[`ADCSQ_C2_SOC1] && !WDATA[`ADCSQ_C2_RST1];
  wire sw2 = wr_c2 && WDATA[`ADCSQ_C2_SOC2] && !WDATA[`ADCSQ_C2_RST2];

  // pin passes two flops, then a rising edge detector on the second
  wire pin_rise = pin_s2_ff && !pin_d_ff;

  // control-two trigger enables as named fields
  wire casc_b_en = ctrl2_ff[`ADCSQ_C2_CASC_B];
  wire pwm_a1_en = ctrl2_ff[`ADCSQ_C2_PWMA1];
  wire pin1_en = ctrl2_ff[`ADCSQ_C2_PIN1];
  wire pwm_b2_en = ctrl2_ff[`ADCSQ_C2_PWMB2];

  wire src_pwm_a = PWM_TRIG_A && pwm_a1_en;
  wire src_pin = pin_rise && pin1_en;
  // the b trigger feeds unit one only while the units are merged
  wire src_casc_b = PWM_TRIG_B && casc_b_en && casc;
  wire hw1 = src_pwm_a || src_pin || src_casc_b;
  wire hw2 = PWM_TRIG_B && pwm_b2_en && !casc;
  wire trig1 = (sw1 || hw1) && !rst1;
  wire trig2 = (sw2 || hw2) && !rst2 && !casc;

  // per-unit state machines: unit one also serves as the merged unit
  adcsq_state_t st_ff [2];
  logic [3:0] pos_ff [2];
  logic [3:0] cnt_ff [2];
  logic [3:0] done_ff [2];
  logic pend_ff [2];
  logic eos_ev [2];
  logic [1:0] go;
  logic [1:0] trg;
  logic [1:0] srst;

  assign trg = {trig2, trig1};
  assign srst = {rst2, rst1};

  // unit two takes the converter only when unit one is idle and not about to start
  assign go[0] = 1'b1;
  assign go[1] = !casc && (st_ff[0] == ADCSQ_IDLE) && !trg[0] && !pend_ff[0];

  genvar u;
  generate
    for (u = 0; u < 2; u = u + 1) begin : g_unit
      wire [3:0] base = (u == 1) ? 4'h8 : 4'h0;
      wire [3:0] last_phys = casc ? 4'hF : (base + 4'h7);
      wire [3:0] max_cnt = (u == 0 && casc) ? maxconv_ff[3:0] : {1'b0, maxconv_ff[2:0]};
      // sequence ends at max count unless override with continuous-run extends it to the last state
      wire at_end = (cont && ovrd) ? (pos_ff[u] == last_phys)
        : ((done_ff[u] == max_cnt) || (pos_ff[u] == last_phys));
      wire [3:0] wrap_pos = (pos_ff[u] == last_phys) ? base : pos_ff[u] + 4'h1;
      wire active = (u == 0) || !casc;
      adcsq_state_t nxt_st;
      logic [3:0] nxt_pos;
      logic [3:0] nxt_cnt;
      logic [3:0] nxt_done;
      logic nxt_pend;
      logic ev;

      always_comb begin
        nxt_st = st_ff[u];
        nxt_pos = pos_ff[u];
        nxt_cnt = cnt_ff[u];
        nxt_done = done_ff[u];
        nxt_pend = pend_ff[u];
        ev = 1'b0;
        case (st_ff[u])
          ADCSQ_IDLE: begin
            if ((trg[u] || pend_ff[u]) && go[u] && active) begin
              nxt_st = ADCSQ_CONV;
              nxt_cnt = 4'h0;
              nxt_pend = 1'b0;
            end else if (trg[u] && active) begin
              nxt_pend = 1'b1;
            end
          end
          ADCSQ_CONV: begin
            if (trg[u]) begin
              nxt_pend = 1'b1;
            end
            if (cnt_ff[u] == CONV_CYCLES - 4'h1) begin
              nxt_st = ADCSQ_STEP;
            end else begin
              nxt_cnt = cnt_ff[u] + 4'h1;
            end
          end
          ADCSQ_STEP: begin
            if (trg[u]) begin
              nxt_pend = 1'b1;
            end
            if (at_end) begin
              ev = 1'b1;
              nxt_done = 4'h0;
              // continuous-run is sampled only here
              if (cont && !ovrd) begin
                nxt_pos = base;
                nxt_st = ADCSQ_CONV;
              end else if (cont) begin
                nxt_pos = wrap_pos;
                nxt_st = ADCSQ_CONV;
              end else begin
                nxt_pos = wrap_pos;
                nxt_st = ADCSQ_IDLE;
              end
            end else begin
              nxt_pos = pos_ff[u] + 4'h1;
              nxt_done = done_ff[u] + 4'h1;
              nxt_st = ADCSQ_CONV;
            end
            nxt_cnt = 4'h0;
          end
          default: nxt_st = ADCSQ_IDLE;
        endcase
        if (srst[u] || (u == 1 && casc)) begin
          nxt_st = ADCSQ_IDLE;
          nxt_pos = base;
          nxt_cnt = 4'h0;
          nxt_done = 4'h0;
          nxt_pend = 1'b0;
        end
      end

      assign eos_ev[u] = ev && !srst[u];

      // one short process per field of the unit
      always_ff @(posedge CLK) begin
        if (!RST_N) begin
          st_ff[u] <= ADCSQ_IDLE;
        end else begin
          st_ff[u] <= nxt_st;
        end
      end

      always_ff @(posedge CLK) begin
        if (!RST_N) begin
          pos_ff[u] <= base;
        end else begin
          pos_ff[u] <= nxt_pos;
        end
      end

      always_ff @(posedge CLK) begin
        if (!RST_N) begin
          cnt_ff[u] <= 4'h0;
        end else begin
          cnt_ff[u] <= nxt_cnt;
        end
      end

      always_ff @(posedge CLK) begin
        if (!RST_N) begin
          done_ff[u] <= 4'h0;
        end else begin
          done_ff[u] <= nxt_done;
        end
      end

      always_ff @(posedge CLK) begin
        if (!RST_N) begin
          pend_ff[u] <= 1'b0;
        end else begin
          pend_ff[u] <= nxt_pend;
        end
      end
    end
  endgenerate

  // register writes; start bits are shown by the pending flags instead
  wire [15:0] nxt_ctrl1 = WDATA & `ADCSQ_C1_MASK;
  wire [15:0] c2_keep = `ADCSQ_C2_MASK & ~(16'h0001 << `ADCSQ_C2_RST1)
    & ~(16'h0001 << `ADCSQ_C2_SOC1) & ~(16'h0001 << `ADCSQ_C2_RST2)
    & ~(16'h0001 << `ADCSQ_C2_SOC2);
  wire [15:0] nxt_ctrl2 = WDATA & c2_keep;
  wire [15:0] c2_view = ctrl2_ff
    | ({15'h0000, pend_ff[0]} << `ADCSQ_C2_SOC1)
    | ({15'h0000, pend_ff[1]} << `ADCSQ_C2_SOC2);
  wire [7:0] nxt_maxconv = WDATA[7:0];
  wire [1:0] nxt_irq_msk = WDATA[1:0];

  // status sources
  wire busy_one = st_ff[0] != ADCSQ_IDLE;
  wire busy_two = st_ff[1] != ADCSQ_IDLE;
  wire [1:0] irq_clr = WDATA[1:0] & {2{wr_is}};
  wire [1:0] irq_set = {eos_ev[1], eos_ev[0]};
  // a clear written in the cycle of a new end event loses, so no event is missed
  wire [1:0] nxt_irq_st = (irq_st_ff & ~irq_clr) | irq_set;
  wire [15:0] stat_view = {pos_ff[1], pos_ff[0], 6'h00, busy_two, busy_one};

  // read selection as one-hot hits, unmapped indices read zero
  wire hit_c1 = ADDR == `ADCSQ_OFS_CTRL1;
  wire hit_c2 = ADDR == `ADCSQ_OFS_CTRL2;
  wire hit_mx = ADDR == `ADCSQ_OFS_MAXCONV;
  wire hit_st = ADDR == `ADCSQ_OFS_STAT;
  wire hit_is = ADDR == `ADCSQ_OFS_IRQ_ST;
  wire hit_im = ADDR == `ADCSQ_OFS_IRQ_MSK;
  wire [15:0] rd_mux = ({16{hit_c1}} & ctrl1_ff)
    | ({16{hit_c2}} & c2_view)
    | ({16{hit_mx}} & {8'h00, maxconv_ff})
    | ({16{hit_st}} & stat_view)
    | ({16{hit_is}} & {14'h0000, irq_st_ff})
    | ({16{hit_im}} & {14'h0000, irq_msk_ff});
  // read data is zero outside its answer cycle so that ports can be or-ed
  wire [15:0] nxt_rdata = RD ? rd_mux : `ADCSQ_RST16;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ctrl1_ff <= `ADCSQ_RST16;
    end else if (wr_c1) begin
      ctrl1_ff <= nxt_ctrl1;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ctrl2_ff <= `ADCSQ_RST16;
    end else if (wr_c2) begin
      ctrl2_ff <= nxt_ctrl2;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      maxconv_ff <= 8'h00;
    end else if (wr_mx) begin
      maxconv_ff <= nxt_maxconv;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      irq_msk_ff <= 2'b00;
    end else if (wr_im) begin
      irq_msk_ff <= nxt_irq_msk;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      irq_st_ff <= 2'b00;
    end else begin
      irq_st_ff <= nxt_irq_st;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rdata_ff <= `ADCSQ_RST16;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // pin synchroniser; the third flop only feeds the edge detector
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      pin_s1_ff <= 1'b0;
      pin_s2_ff <= 1'b0;
      pin_d_ff <= 1'b0;
    end else begin
      pin_s1_ff <= PIN_TRIG;
      pin_s2_ff <= pin_s1_ff;
      pin_d_ff <= pin_s2_ff;
    end
  end

  assign RDATA = rdata_ff;
  assign UNIT_ONE_STATE = pos_ff[0];
  assign UNIT_TWO_STATE = pos_ff[1];
  assign UNIT_ONE_BUSY = busy_one;
  assign UNIT_TWO_BUSY = busy_two;
  // unit two's slot start is hidden while unit one holds the converter
  wire start_one = (st_ff[0] == ADCSQ_CONV) && (cnt_ff[0] == 4'h0);
  wire start_two = (st_ff[1] == ADCSQ_CONV) && (cnt_ff[1] == 4'h0) && !busy_one;
  assign CONV_START = start_one || start_two;
  assign CONV_INDEX = busy_one ? pos_ff[0] : pos_ff[1];
  assign IRQ = |(irq_st_ff & irq_msk_ff);

endmodule // adcsq_run_ctrl

// File: test/adcsq_run_ctrl_asserts.sv
// port checker of the sequencer run control
`timescale 1ns/1ps
module adcsq_run_ctrl_chk #(
  parameter logic [3:0] CONV_CYCLES = 4'h4
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [3:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [15:0] RDATA,
  input wire logic [3:0] UNIT_ONE_STATE,
  input wire logic [3:0] UNIT_TWO_STATE,
  input wire logic UNIT_ONE_BUSY,
  input wire logic UNIT_TWO_BUSY,
  input wire logic CONV_START
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  sequence s_c2_wr;
    WR && ADDR == 4'h1;
  endsequence
  sequence s_idle;
    !UNIT_ONE_BUSY && !UNIT_TWO_BUSY;
  endsequence
  chk_rdata_quiet: assert property (!RD |=> RDATA == 16'h0000)
    else $error("read data not zero outside answer");
  chk_reset_abort: assert property (
    s_c2_wr ##0 WDATA[14] |=> !UNIT_ONE_BUSY && UNIT_ONE_STATE == 4'h0)
    else $error("unit one not aborted");
  chk_two_reset: assert property (
    s_c2_wr ##0 WDATA[6] |=> !UNIT_TWO_BUSY && UNIT_TWO_STATE == 4'h8)
    else $error("unit two not reset to eight");
  chk_idle_start: assert property (
    s_idle ##0 s_c2_wr ##0 (WDATA[14:13] == 2'b01) |=> UNIT_ONE_BUSY && CONV_START)
    else $error("idle start not immediate");
  // the slot is CONV_CYCLES plus one step cycle; writes excluded since abort may restart
  chk_slot_len: assert property (CONV_START ##1 !WR [*3] |=> !CONV_START)
    else $error("slot shorter than five cycles");
  chk_start_busy: assert property (CONV_START |-> UNIT_ONE_BUSY || UNIT_TWO_BUSY)
    else $error("conversion start while idle");
  chk_two_range: assert property (UNIT_TWO_BUSY |-> UNIT_TWO_STATE[3])
    else $error("unit two below state eight");
  chk_c1_reserved: assert property (
    RD && ADDR == 4'h0 |=> RDATA[3:0] == 4'h0)
    else $error("ctrl one low bits not zero");
  chk_c2_reserved: assert property (
    RD && ADDR == 4'h1 |=> (RDATA & 16'h1212) == 16'h0000)
    else $error("ctrl two reserved bits not zero");
endmodule // adcsq_run_ctrl_chk

// File: test/adcsq_pwm_src.sv
// pwm trigger source model: one-cycle start pulses on request
`timescale 1ns/1ps
module adcsq_pwm_src (
  input wire logic clk,
  input wire logic fire_a,
  input wire logic fire_b,
  output logic trig_a = 1'b0,
  output logic trig_b = 1'b0
);
  logic fire_a_d = 1'b0;
  logic fire_b_d = 1'b0;
  // a held request still gives a single pulse, as an edge-made trigger does
  always @(posedge clk) begin
    fire_a_d <= fire_a;
    fire_b_d <= fire_b;
    trig_a <= fire_a && !fire_a_d;
    trig_b <= fire_b && !fire_b_d;
  end
endmodule // adcsq_pwm_src

// File: test/tb_adc_sequencer_run_control.sv
// self-checking bench of the sequencer run control
`timescale 1ns/1ps
module tb_adc_sequencer_run_control;
  logic CLK = 0, RST_N = 0, WR = 0, RD = 0, PIN = 0, fa = 0, fb = 0;
  logic [3:0] ADDR = 4'h0;
  logic [15:0] WDATA = 16'h0000;
  wire logic [15:0] RDATA;
  wire logic [3:0] S1, S2, IDX;
  wire logic B1, B2, CS, IRQ, TA, TB;
  int n_fail = 0, num_checks = 0, cyc = 0;
  always #20 CLK = ~CLK;
  always @(posedge CLK) if (++cyc > 5000) begin
    n_fail++;
    give_verdict();
  end
  adcsq_pwm_src i_src (.clk(CLK), .fire_a(fa), .fire_b(fb), .trig_a(TA), .trig_b(TB));
  adcsq_run_ctrl i_dut (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .PWM_TRIG_A(TA), .PWM_TRIG_B(TB), .PIN_TRIG(PIN),
    .UNIT_ONE_STATE(S1), .UNIT_TWO_STATE(S2), .UNIT_ONE_BUSY(B1), .UNIT_TWO_BUSY(B2),
    .CONV_START(CS), .CONV_INDEX(IDX), .IRQ(IRQ));
  task automatic chk(string nm, logic [15:0] ex, logic [15:0] got);
    num_checks++;
    if (got !== ex) begin
      n_fail++;
      $display("[FAIL] %s exp %h got %h", nm, ex, got);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [15:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  task automatic rdc(string nm, logic [3:0] a, logic [15:0] ex);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 chk(nm, ex, RDATA);
  endtask
  // lets two edges pass so that a level output is looked at once settled
  task automatic settle;
    repeat (2) @(posedge CLK);
    #1;
  endtask
  // counts slot starts until both units have stayed idle for four cycles
  task automatic run(output int n);
    int q = 0;
    n = 0;
    #1;
    while (q < 4) begin
      n += (CS === 1'b1);
      q = (B1 === 1'b0 && B2 === 1'b0) ? q + 1 : 0;
      @(posedge CLK);
      #1;
    end
  endtask
  task automatic seq(int n, int b, int m);
    for (int i = 0; i < n; i++) begin
      @(posedge CLK iff CS === 1'b1);
      chk("index", 16'(b + i % m), {12'h000, IDX});
    end
  endtask
  task automatic t_regs;
    rdc("ctrl1", 4'h0, 16'h0000);
    rdc("ctrl2", 4'h1, 16'h0000);
    wr(4'h0, 16'hFFFF);
    rdc("ctrl1", 4'h0, 16'h0070);
    wr(4'h1, 16'h9F9F);
    rdc("ctrl2", 4'h1, 16'h8D8D);
    rdc("unmapped", 4'hF, 16'h0000);
    wr(4'h1, 16'h0000);
    wr(4'h0, 16'h0000);
  endtask
  task automatic t_stop;
    int n;
    wr(4'h2, 16'h0001);
    wr(4'h1, 16'h6000);
    run(n);
    chk("starts", 16'h0, 16'(n));
    wr(4'h1, 16'h2000);
    wr(4'h1, 16'h2000);
    rdc("pending", 4'h1, 16'h2000);
    wr(4'h1, 16'h2000);
    run(n);
    chk("halt pos", 16'h0004, {12'h000, S1});
    rdc("status", 4'h3, 16'h8400);
  endtask
  task automatic t_irq;
    rdc("irq st", 4'h4, 16'h0001);
    settle;
    chk("irq masked", 16'h0, {15'h0, IRQ});
    wr(4'h5, 16'h0001);
    settle;
    chk("irq on", 16'h1, {15'h0, IRQ});
    wr(4'h4, 16'h0001);
    settle;
    chk("irq clr", 16'h0, {15'h0, IRQ});
    wr(4'h5, 16'h0000);
  endtask
  task automatic t_cont;
    int n;
    wr(4'h1, 16'h4000);
    wr(4'h0, 16'h0040);
    wr(4'h1, 16'h2000);
    seq(5, 0, 2);
    wr(4'h0, 16'h0000);
    run(n);
    chk("stop pos", 16'h0002, {12'h000, S1});
    wr(4'h1, 16'h4000);
    wr(4'h0, 16'h0060);
    wr(4'h1, 16'h2000);
    seq(10, 0, 8);
    wr(4'h1, 16'h4000);
    #1 chk("abort", 16'h0, {11'h0, B1, S1});
  endtask
  task automatic pulse(input bit sel_b);
    @(posedge CLK);
    if (sel_b) fb <= 1'b1;
    else fa <= 1'b1;
    @(posedge CLK);
    fa <= 1'b0;
    fb <= 1'b0;
  endtask
  task automatic t_casc;
    int n;
    wr(4'h0, 16'h0000);
    wr(4'h1, 16'h8000);
    pulse(1'b1);
    settle;
    chk("dual b", 16'h0, {14'h0, B1, B2});
    wr(4'h0, 16'h0010);
    wr(4'h2, 16'h0009);
    fork
      pulse(1'b1);
      seq(10, 0, 16);
    join
    run(n);
    chk("casc pos", 16'h000A, {12'h000, S1});
  endtask
  task automatic t_trig;
    int n;
    wr(4'h0, 16'h0000);
    wr(4'h1, 16'h4000);
    wr(4'h1, 16'h0180);
    fork
      pulse(1'b0);
      seq(1, 0, 1);
    join
    run(n);
    PIN <= 1'b1;
    seq(1, 2, 1);
    PIN <= 1'b0;
    run(n);
  endtask
  task automatic t_two;
    wr(4'h1, 16'h0040);
    wr(4'h0, 16'h0060);
    wr(4'h1, 16'h0020);
    seq(9, 8, 8);
    wr(4'h1, 16'h0040);
    #1 chk("two abort", 16'h0, {15'h0, B2});
  endtask
  task automatic give_verdict;
    if (n_fail == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge CLK);
    RST_N <= 1'b1;
    t_regs;
    t_stop;
    t_irq;
    t_cont;
    t_casc;
    t_trig;
    t_two;
    give_verdict;
  end
endmodule // tb_adc_sequencer_run_control
bind adcsq_run_ctrl adcsq_run_ctrl_chk #(.CONV_CYCLES(CONV_CYCLES)) i_chk (
  .CLK(CLK),
  .RST_N(RST_N),
  .ADDR(ADDR),
  .WDATA(WDATA),
  .WR(WR),
  .RD(RD),
  .RDATA(RDATA),
  .UNIT_ONE_STATE(UNIT_ONE_STATE),
  .UNIT_TWO_STATE(UNIT_TWO_STATE),
  .UNIT_ONE_BUSY(UNIT_ONE_BUSY),
  .UNIT_TWO_BUSY(UNIT_TWO_BUSY),
  .CONV_START(CONV_START)
);
